// ==== core/tcr_core.sv ====
// per-channel transceiver reset control with wishbone registers
module tcr_core
  import tcr_pkg::*;
#(
  parameter bit MANUAL_EN  = 1'b0,
  parameter bit FAST_CTRL  = 1'b0,
  parameter bit FAST_SEQ   = 1'b0,
  parameter bit INDIV_EN   = 1'b1,
  parameter bit SEPARATE   = 1'b1,
  parameter bit TXRX_SEQ   = 1'b1,
  parameter bit PAM4_HR    = 1'b0,
  parameter bit MS_OPT2    = 1'b0,
  parameter int MASTER_CH  = 0,
  parameter int FILT_CYCLES = tcr_pkg::FILT_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire tcr_pkg::tcr_wb_req_t  wb_req_i,
  output tcr_pkg::tcr_wb_rsp_t       wb_rsp_o,
  input  wire logic [tcr_pkg::NCH-1:0] reset_i,
  input  wire logic [tcr_pkg::NCH-1:0] tx_reset_i,
  input  wire logic [tcr_pkg::NCH-1:0] rx_reset_i,
  input  wire tcr_pkg::tcr_rst_t     byp_rst_i,
  input  wire logic [tcr_pkg::NCH-1:0] tx_cal_done_i,
  input  wire logic [tcr_pkg::NCH-1:0] rx_cal_done_i,
  input  wire logic [tcr_pkg::NCH-1:0] rx_cdr_lock_i,
  output tcr_pkg::tcr_rst_t          dp_rst_o,
  output logic [tcr_pkg::NCH-1:0]    tx_analog_ready_o,
  output logic [tcr_pkg::NCH-1:0]    rx_analog_ready_o,
  output logic [tcr_pkg::NCH-1:0]    rx_cdr_lock_o,
  output logic [tcr_pkg::NCH-1:0]    tx_link_ready_o,
  output logic [tcr_pkg::NCH-1:0]    rx_link_ready_o,
  output logic [tcr_pkg::NCH-1:0]    tx_done_o,
  output logic [tcr_pkg::NCH-1:0]    rx_done_o,
  output logic                       xfer_clk_en_o
);
  import tcr_pkg::*;

  localparam logic [15:0] FILT_RST = 16'(FILT_CYCLES / STEP_CYC);
  localparam logic [3:0]  DLY  = FAST_SEQ ? FAST_DONE_DLY : DONE_DLY;
  localparam int          DONE_MAX = 8;

  tcr_state_t q;
  tcr_state_t d;
  logic [NCH-1:0]  tx_ana;
  logic [NCH-1:0]  rx_ana;
  logic [NCH-1:0]  lock;
  logic [NCH-1:0]  tx_gate;
  logic [NCH-1:0]  rx_gate;
  logic [NCH-1:0]  lk_gate;
  logic [CW-1:0]   filt_len;
  logic            wr;
  logic            rd;

  // settled pin levels, grouped as tx cal, rx cal, lock
  assign tx_ana = q.pin[NCH-1:0];
  assign rx_ana = q.pin[2*NCH-1:NCH];
  assign lock   = q.pin[3*NCH-1:2*NCH];

  // without separation one bad channel holds every channel back
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (SEPARATE || NCH == 1) begin
        tx_gate[i] = tx_ana[i];
        rx_gate[i] = rx_ana[i];
        lk_gate[i] = lock[i];
      end else begin
        tx_gate[i] = &tx_ana;
        rx_gate[i] = &rx_ana;
        lk_gate[i] = &lock;
      end
    end
  end

  // filter length: software steps, or a short figure for fast simulation
  always_comb begin
    if (FAST_CTRL) begin
      filt_len = CW'(FAST_FILT_CYC);
    end else if (q.filt_steps == 16'h0000) begin
      filt_len = CW'(STEP_CYC);
    end else begin
      filt_len = CW'(q.filt_steps) * CW'(STEP_CYC);
    end
  end

  // writes land at the edge where the master sees ack, request still held
  assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && q.wb.ack;
  assign rd = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !q.wb.ack;

  // next state of the whole block
  always_comb begin
    logic sel_rst;
    logic tx_req;
    logic rx_req;
    int   ri;
    sel_rst = 1'b0;
    tx_req  = 1'b0;
    rx_req  = 1'b0;
    ri      = 0;
    d = q;
    // three-stage pin capture, a bit changes once stages 2 and 3 agree
    d.sync[0] = {rx_cdr_lock_i, rx_cal_done_i, tx_cal_done_i};
    d.sync[1] = q.sync[0];
    d.sync[2] = q.sync[1];
    d.pin = (q.sync[1] & q.sync[2]) | (q.pin & (q.sync[1] | q.sync[2]));
    // with separation each channel runs on its own, nothing staggers them
    for (int i = 0; i < NCH; i++) begin
      ri = PAM4_HR ? (i >> 1) : i;
      sel_rst = INDIV_EN ? tx_reset_i[ri] : reset_i[ri];
      tx_req = sel_rst || q.sw_tx[i] || !tx_gate[i];
      sel_rst = INDIV_EN ? rx_reset_i[ri] : reset_i[ri];
      rx_req = sel_rst || q.sw_rx[i] || !rx_gate[i];
      // tx sequencer: done a few cycles after release
      d.tx_rst[i] = tx_req;
      if (q.tx_rst[i]) begin
        d.tx_done[i] = 1'b0;
        d.tx_cnt[i]  = 4'h0;
      end else if (!q.tx_done[i]) begin
        d.tx_cnt[i] = q.tx_cnt[i] + 4'h1;
        if (q.tx_cnt[i] == DLY - 4'h1) begin
          d.tx_done[i] = 1'b1;
        end
      end
      // rx sequencer: lock must stay high for the whole filter time
      if (rx_req) begin
        d.rx_st[i]   = RX_HOLD;
        d.rx_done[i] = 1'b0;
        d.flt[i]     = '0;
      end else begin
        case (q.rx_st[i])
          RX_HOLD: begin
            d.rx_st[i] = RX_FILT;
            d.flt[i]   = '0;
          end
          RX_FILT: begin
            // a pulsing lock restarts the count
            if (!lk_gate[i]) begin
              d.flt[i] = '0;
            end else if (q.flt[i] < filt_len) begin
              d.flt[i] = q.flt[i] + CW'(1);
            end else if (!TXRX_SEQ || q.tx_done[i]) begin
              d.rx_st[i] = RX_WAIT;
              d.flt[i]   = '0;
            end
          end
          RX_WAIT: begin
            d.flt[i] = q.flt[i] + CW'(1);
            if (q.flt[i] == CW'(DLY - 4'h1)) begin
              d.rx_st[i]   = RX_RUN;
              d.rx_done[i] = 1'b1;
            end
          end
          RX_RUN: begin
            d.rx_st[i] = RX_RUN;
          end
          default: begin
            d.rx_st[i] = RX_HOLD;
          end
        endcase
      end
    end
    // datapath resets: bypass passes user inputs, else sequencer drives
    if (MANUAL_EN) begin
      d.rout = byp_rst_i;
    end else begin
      d.rout.tx_link = q.tx_rst;
      d.rout.tx_aif  = q.tx_rst;
      d.rout.tx_fec  = q.tx_rst;
      for (int i = 0; i < NCH; i++) begin
        d.rout.rx_link[i] = (q.rx_st[i] == RX_HOLD) ||
                            (q.rx_st[i] == RX_FILT);
      end
      d.rout.rx_aif = d.rout.rx_link;
      d.rout.rx_fec = d.rout.rx_link;
      d.rout.fec    = byp_rst_i.fec;
    end
    // global fec reset reaches both fec paths
    d.rout.tx_fec = d.rout.tx_fec | d.rout.fec;
    d.rout.rx_fec = d.rout.rx_fec | d.rout.fec;
    // ready drops with the link reset, rises one cycle after release
    d.tx_lrdy = ~q.rout.tx_link & ~d.rout.tx_link & tx_gate;
    d.rx_lrdy = ~q.rout.rx_link & ~d.rout.rx_link & rx_gate;
    // the master's link reset halts the forwarded transfer clock
    d.clk_fwd = !(MS_OPT2 && q.rout.tx_link[MASTER_CH]);
    // bus slave: one cycle answer, unmapped reads zero
    d.wb.ack = wb_req_i.cyc && wb_req_i.stb && !q.wb.ack;
    d.wb.dat = 32'h0000_0000;
    if (wr && wb_req_i.adr == REG_CTRL && wb_req_i.sel[0]) begin
      d.sw_tx = wb_req_i.dat[CTRL_TX_LSB +: NCH];
      d.sw_rx = wb_req_i.dat[CTRL_RX_LSB +: NCH];
    end
    if (wr && wb_req_i.adr == REG_FILT) begin
      if (wb_req_i.sel[0]) begin
        d.filt_steps[7:0] = wb_req_i.dat[7:0];
      end
      if (wb_req_i.sel[1]) begin
        d.filt_steps[15:8] = wb_req_i.dat[15:8];
      end
    end
    if (rd) begin
      case (wb_req_i.adr)
        REG_CTRL: begin
          d.wb.dat[CTRL_TX_LSB +: NCH] = q.sw_tx;
          d.wb.dat[CTRL_RX_LSB +: NCH] = q.sw_rx;
        end
        REG_FILT: begin
          d.wb.dat[15:0] = q.filt_steps;
        end
        REG_STAT: begin
          d.wb.dat[ST_TXD_LSB +: NCH] = q.tx_done;
          d.wb.dat[ST_RXD_LSB +: NCH] = q.rx_done;
          d.wb.dat[ST_TXA_LSB +: NCH] = tx_ana;
          d.wb.dat[ST_RXA_LSB +: NCH] = rx_ana;
          d.wb.dat[ST_LCK_LSB +: NCH] = lock;
          d.wb.dat[ST_TXL_LSB +: NCH] = q.tx_lrdy;
          d.wb.dat[ST_RXL_LSB +: NCH] = q.rx_lrdy;
        end
        default: begin
          d.wb.dat = 32'h0000_0000;
        end
      endcase
    end
  end

  // single state register; rst_i loads it whatever ce_i is, otherwise it is frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q            <= '0;
      q.rx_st      <= '{default: RX_HOLD};
      q.tx_rst     <= {NCH{1'b1}};
      q.rout       <= '1;
      q.clk_fwd    <= 1'b0;
      q.sw_tx      <= CTRL_RST;
      q.sw_rx      <= CTRL_RST;
      q.filt_steps <= FILT_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign wb_rsp_o          = q.wb;
  assign dp_rst_o          = q.rout;
  assign tx_analog_ready_o = tx_ana; // tx calibration complete
  assign rx_analog_ready_o = rx_ana; // cdr calibration complete
  assign rx_cdr_lock_o     = lock; // not filtered, may pulse
  assign tx_link_ready_o   = q.tx_lrdy;
  assign rx_link_ready_o   = q.rx_lrdy;
  assign tx_done_o         = MANUAL_EN ? '0 : q.tx_done;
  assign rx_done_o         = MANUAL_EN ? '0 : q.rx_done;
  assign xfer_clk_en_o     = q.clk_fwd;

  // checks; hold ce_i high while they are meant to hold
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  fec_both_a: assert property (
    (dp_rst_o.fec & dp_rst_o.tx_fec & dp_rst_o.rx_fec) == dp_rst_o.fec)
    else $error("global fec reset missed a path");
  link_rdy_a: assert property (
    (dp_rst_o.tx_link & tx_link_ready_o) == '0)
    else $error("tx link ready while link in reset");
  link_rise_a: assert property (
    ##1 ($fell(dp_rst_o.rx_link[0]) && rx_gate[0]) |=> rx_link_ready_o[0])
    else $error("rx link ready late");
  clk_fwd_a: assert property (
    MS_OPT2 && dp_rst_o.tx_link[MASTER_CH] |=> !xfer_clk_en_o)
    else $error("transfer clock still forwarded");
  done_drop_a: assert property (
    !MANUAL_EN && q.tx_rst[0] |=> !tx_done_o[0])
    else $error("tx done high during reset");
  done_rise_a: assert property (
    !MANUAL_EN && $fell(q.tx_rst[0]) ##1 !q.tx_rst[0] [*4]
    |-> ##[0:DONE_MAX] tx_done_o[0])
    else $error("tx done did not rise");
  seq_order_a: assert property (
    TXRX_SEQ && $rose(rx_done_o[1]) |-> $past(tx_done_o[1], 2))
    else $error("rx released before tx");
  filt_hold_a: assert property (
    q.rx_st[0] == RX_FILT && !lk_gate[0] |=> q.flt[0] == '0)
    else $error("lock filter not restarted");
  bypass_a: assert property (
    MANUAL_EN |=> dp_rst_o.tx_aif == $past(byp_rst_i.tx_aif))
    else $error("bypass reset not passed through");
  gate_a: assert property (
    !SEPARATE && NCH > 1 && !(&tx_ana) |=> &q.tx_rst)
    else $error("channel not gated by others");

  tx_up_c: cover property ($rose(tx_done_o[0]));
  rx_up_c: cover property ($rose(rx_done_o[0]));
  relock_c: cover property (q.rx_st[0] == RX_FILT ##1 !lk_gate[0]);
  wb_c: cover property (wb_req_i.we && wb_rsp_o.ack);
endmodule : tcr_core

// ==== core/tcr_pkg.sv ====
// shared constants and types for the channel reset control block
package tcr_pkg;
  localparam int NCH        = 4;
  localparam int NA         = 3 * NCH;
  localparam int CLK_MHZ    = 100;
  // filter time for cdr lock, in its own unit, and its cycle count
  localparam int FILT_TIME_NS = 180000;
  localparam int FILT_CYC   = (FILT_TIME_NS * CLK_MHZ + 999) / 1000;
  // filter time is programmed in steps of this minimum
  localparam int STEP_NS    = 100;
  localparam int STEP_CYC   = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int FAST_FILT_CYC = 20;
  localparam logic [3:0] DONE_DLY      = 4'h4;
  localparam logic [3:0] FAST_DONE_DLY = 4'h1;
  localparam int CW = 20;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FILT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  // field positions
  localparam int CTRL_TX_LSB = 0;
  localparam int CTRL_RX_LSB = 4;
  localparam int ST_TXD_LSB  = 0;
  localparam int ST_RXD_LSB  = 4;
  localparam int ST_TXA_LSB  = 8;
  localparam int ST_RXA_LSB  = 12;
  localparam int ST_LCK_LSB  = 16;
  localparam int ST_TXL_LSB  = 20;
  localparam int ST_RXL_LSB  = 24;
  localparam logic [NCH-1:0] CTRL_RST = 4'h0;

  typedef enum logic [1:0] {RX_HOLD, RX_FILT, RX_WAIT, RX_RUN} tcr_rx_st_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcr_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tcr_wb_rsp_t;

  typedef struct packed {
    logic [NCH-1:0] tx_link;
    logic [NCH-1:0] rx_link;
    logic [NCH-1:0] tx_aif;
    logic [NCH-1:0] rx_aif;
    logic [NCH-1:0] tx_fec;
    logic [NCH-1:0] rx_fec;
    logic [NCH-1:0] fec;
  } tcr_rst_t;

  typedef struct packed {
    logic [2:0][NA-1:0]      sync;
    logic [NA-1:0]           pin;
    logic [NCH-1:0]          tx_rst;
    logic [NCH-1:0]          tx_done;
    logic [NCH-1:0][3:0]     tx_cnt;
    tcr_rx_st_t [NCH-1:0]    rx_st;
    logic [NCH-1:0]          rx_done;
    logic [NCH-1:0][CW-1:0]  flt;
    tcr_rst_t                rout;
    logic [NCH-1:0]          tx_lrdy;
    logic [NCH-1:0]          rx_lrdy;
    logic                    clk_fwd;
    logic [NCH-1:0]          sw_tx;
    logic [NCH-1:0]          sw_rx;
    logic [15:0]             filt_steps;
    tcr_wb_rsp_t             wb;
  } tcr_state_t;
endpackage : tcr_pkg

// ==== tb/tb.sv ====
// self-checking bench for the channel reset control block
module tb;
  import tcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, ce_i, noisy;
  tcr_wb_req_t wb_req;
  tcr_wb_rsp_t wb_rsp;
  tcr_rst_t byp, dp_rst;
  logic [NCH-1:0] reset_v, tx_rst, rx_rst, tx_cal, rx_cal, data;
  logic [NCH-1:0] txc_pin, rxc_pin, lck_pin, tx_ana, rx_ana, lck;
  logic [NCH-1:0] tx_lrdy, rx_lrdy, tx_done, rx_done;
  logic xfer_en;
  logic [31:0] rd;
  int num_errors, num_checks, n;

  tcr_core #(.FAST_SEQ(1'b1), .MS_OPT2(1'b1), .MASTER_CH(0),
    .FILT_CYCLES(40)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .reset_i(reset_v),
    .tx_reset_i(tx_rst), .rx_reset_i(rx_rst), .byp_rst_i(byp),
    .tx_cal_done_i(txc_pin), .rx_cal_done_i(rxc_pin),
    .rx_cdr_lock_i(lck_pin), .dp_rst_o(dp_rst),
    .tx_analog_ready_o(tx_ana), .rx_analog_ready_o(rx_ana),
    .rx_cdr_lock_o(lck), .tx_link_ready_o(tx_lrdy),
    .rx_link_ready_o(rx_lrdy), .tx_done_o(tx_done),
    .rx_done_o(rx_done), .xfer_clk_en_o(xfer_en));

  tcr_far_model far (.clk_i(clk_i), .tx_cal_i(tx_cal), .rx_cal_i(rx_cal),
    .data_i(data), .noisy_i(noisy), .tx_cal_done_o(txc_pin),
    .rx_cal_done_o(rxc_pin), .rx_cdr_lock_o(lck_pin));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc_n

  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] wd);
    int i;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: wd};
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (wb_rsp.ack === 1'b1) break;
    end
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_i);
    if (i == 50) begin
      chk("bus ack", 32'h1, 32'h0);
      report_and_stop();
    end
  endtask : wb

  // bounded wait for a done flag; n counts the edges waited
  task automatic wait_done(input int ch, input logic rx);
    for (n = 1; n < 300; n++) begin
      @(posedge clk_i);
      if ((rx ? rx_done[ch] : tx_done[ch]) === 1'b1) return;
    end
    chk("done wait", 32'h1, 32'h0);
    report_and_stop();
  endtask : wait_done

  initial begin
    rst_i = 1'b1; ce_i = 1'b1; wb_req = '0; byp = '0; noisy = 1'b0;
    reset_v = '0; tx_rst = '0; rx_rst = '0;
    tx_cal = '1; rx_cal = '1; data = '1;
    num_errors = 0; num_checks = 0;
    cyc_n(2);
    rst_i <= 1'b0;
    for (int c = 0; c < NCH; c++) begin
      wait_done(c, 1'b0);
      wait_done(c, 1'b1);
    end
    cyc_n(3);
    // register map, unmapped place, filter write and read back
    wb(1'b0, REG_STAT, 32'h0); chk("stat", 32'h0fffffff, rd);
    wb(1'b0, REG_FILT, 32'h0); chk("filt", 32'h4, rd);
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h0c, 32'h0); chk("unmapped", 32'h0, rd);
    wb(1'b0, REG_CTRL, 32'h0); chk("ctrl", 32'h0, rd);
    wb(1'b1, REG_FILT, 32'h3);
    wb(1'b0, REG_FILT, 32'h0); chk("filt wr", 32'h3, rd);
    // one instance, fec off, no manual or automatic peers
    // pulses all 4 cycles or longer
    // two channels in reset together; analog ready high
    tx_rst[0] <= 1'b1; rx_rst[0] <= 1'b1; rx_rst[2] <= 1'b1;
    cyc_n(4);
    chk("tx_done0", 32'h0, tx_done[0]);
    chk("tx_link0", 32'h1, dp_rst.tx_link[0]);
    chk("rx_link2", 32'h1, dp_rst.rx_link[2]);
    chk("tx_lrdy0", 32'h0, tx_lrdy[0]);
    chk("xfer_en", 32'h0, xfer_en);
    chk("tx_done1", 32'h1, tx_done[1]);
    // rx released first must still wait for tx
    rx_rst[0] <= 1'b0;
    cyc_n(80);
    chk("rx_done0", 32'h0, rx_done[0]);
    tx_rst[0] <= 1'b0;
    wait_done(0, 1'b0); chk("tx rise", 32'h1, n <= 8);
    wait_done(0, 1'b1);
    chk("xfer_en on", 32'h1, xfer_en);
    // pulsing lock must not end the filter
    data[2] <= 1'b0; noisy <= 1'b1;
    cyc_n(2);
    rx_rst[2] <= 1'b0;
    cyc_n(150);
    chk("rx_done2", 32'h0, rx_done[2]);
    data[2] <= 1'b1;
    wait_done(2, 1'b1); chk("filt len", 32'h1, n >= 30 && n <= 50);
    noisy <= 1'b0;
    // global fec reset reaches both paths
    byp.fec[3] <= 1'b1; // tx analog ready high
    cyc_n(10); // pulse held 100 ns
    chk("fec tx", 32'h1, dp_rst.tx_fec[3]);
    chk("fec rx", 32'h1, dp_rst.rx_fec[3]);
    byp.fec[3] <= 1'b0;
    cyc_n(10);
    chk("fec off", 32'h0, {dp_rst.tx_fec[3], dp_rst.rx_fec[3]});
    // calibration loss on one channel only
    rx_cal[1] <= 1'b0;
    cyc_n(7);
    chk("rx_ana1", 32'h0, rx_ana[1]);
    chk("rx_lrdy1", 32'h0, rx_lrdy[1]);
    chk("rx_ana0", 32'h1, rx_ana[0]);
    rx_cal[1] <= 1'b1;
    wait_done(1, 1'b1);
    // software rx reset through the control register
    wb(1'b1, REG_CTRL, 32'h00000020);
    cyc_n(3);
    chk("sw rx1", 32'h0, rx_done[1]);
    wb(1'b1, REG_CTRL, 32'h0);
    wait_done(1, 1'b1);
    report_and_stop();
  end
endmodule : tb

// ==== tb/tcr_far_model.sv ====
// far-side model: calibration and cdr lock pins of every channel
module tcr_far_model
  import tcr_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic [tcr_pkg::NCH-1:0] tx_cal_i,
  input  wire logic [tcr_pkg::NCH-1:0] rx_cal_i,
  input  wire logic [tcr_pkg::NCH-1:0] data_i,
  input  wire logic                    noisy_i,
  output logic [tcr_pkg::NCH-1:0]      tx_cal_done_o,
  output logic [tcr_pkg::NCH-1:0]      rx_cal_done_o,
  output logic [tcr_pkg::NCH-1:0]      rx_cdr_lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  // calibration pins follow the bench with one register of lag
  always_ff @(posedge clk_i) begin
    ph <= ph + 2'h1;
    tx_cal_done_o <= tx_cal_i;
    rx_cal_done_o <= rx_cal_i;
  end
  // no serial data: lock pulses briefly, shorter than any filter
  always_comb begin
    rx_cdr_lock_o = data_i | (noisy_i ? {NCH{ph == 2'h0}} : '0);
  end
  initial ph = 2'h0;
endmodule : tcr_far_model
